// ---- core/agpc_pkg.sv ----
// Constants and types for the port command register
`default_nettype none
package agpc_pkg;
  // Register map (byte address)
  localparam logic [7:0]  CMD_OFS  = 8'hA8;
  localparam logic [31:0] RST_V20  = 32'h0000_0000;
  localparam logic [31:0] RST_V30  = 32'h0000_0A00;
  localparam logic [31:0] WR_MASK  = 32'h0000_1F17;
  localparam logic [31:0] RD_MASK  = 32'h0000_1F17;
  // Field positions
  localparam int CAL_HI  = 12;
  localparam int CAL_LO  = 10;
  localparam int SBA_BIT = 9;
  localparam int EN_BIT  = 8;
  localparam int G4_BIT  = 5;
  localparam int FW_BIT  = 4;
  localparam int RATE_HI = 2;
  // Calibration period codes
  localparam logic [2:0] CAL_4    = 3'h0;
  localparam logic [2:0] CAL_16   = 3'h1;
  localparam logic [2:0] CAL_64   = 3'h2;
  localparam logic [2:0] CAL_256  = 3'h3;
  localparam logic [2:0] CAL_NONE = 3'h7;
  // One-hot rate select codes
  localparam logic [2:0] RSEL_0 = 3'h1;
  localparam logic [2:0] RSEL_1 = 3'h2;
  localparam logic [2:0] RSEL_2 = 3'h4;
  // Timing
  localparam int CLK_KHZ  = 25000;
  localparam int T4_MS    = 4;
  localparam int T16_MS   = 16;
  localparam int T64_MS   = 64;
  localparam int T256_MS  = 256;
  localparam int CAL4_CYC   = T4_MS * CLK_KHZ;
  localparam int CAL16_CYC  = T16_MS * CLK_KHZ;
  localparam int CAL64_CYC  = T64_MS * CLK_KHZ;
  localparam int CAL256_CYC = T256_MS * CLK_KHZ;
  localparam int CNT_W      = 24;

  typedef enum logic [2:0] {
    RATE_NONE = 3'b000, RATE_1X = 3'b001, RATE_2X = 3'b010,
    RATE_4X = 3'b011, RATE_8X = 3'b100
  } agpc_rate_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00, OP_PIPE = 2'b01, OP_SBA = 2'b10
  } agpc_op_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } agpc_wb_req_t;
endpackage
`default_nettype wire

// ---- core/agpc_command_reg.sv ----
// Port command register with Wishbone slave and operation gating
//
// The implementer's own choice: the Wishbone interface to the registers.
`default_nettype none
module agpc_command_reg #(
  parameter int CAL4_CYC   = agpc_pkg::CAL4_CYC,
  parameter int CAL16_CYC  = agpc_pkg::CAL16_CYC,
  parameter int CAL64_CYC  = agpc_pkg::CAL64_CYC,
  parameter int CAL256_CYC = agpc_pkg::CAL256_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire agpc_pkg::agpc_wb_req_t wb_req,
  output var  logic [31:0]            wb_dat_o,
  output var  logic                   wb_ack_o,
  input  wire logic                   vref_3p0,
  input  wire logic                   pwrok,
  input  wire logic                   pipe_req_n,
  input  wire logic                   sba_start,
  input  wire logic                   op_last,
  output var  logic                   mode_3p0_r,
  output var  logic                   port_enable_r,
  output var  logic                   sba_enabled_r,
  output var  logic                   op_accept_r,
  output var  logic                   op_sba_r,
  output var  logic                   op_busy_r,
  output var  logic                   op_issue_r,
  output var  logic                   fast_write_r,
  output var  agpc_pkg::agpc_rate_t   xfer_rate_r,
  output var  logic                   cal_pulse_r
);
  localparam int CW = agpc_pkg::CNT_W;

  generate
    if (CAL4_CYC < 1 || CAL16_CYC < 1 || CAL64_CYC < 1 || CAL256_CYC < 1 ||
        CAL4_CYC >= (1 << CW) || CAL16_CYC >= (1 << CW) ||
        CAL64_CYC >= (1 << CW) || CAL256_CYC >= (1 << CW))
    begin : g_bad_cal
      $error("calibration counts must be at least one and fit the counter");
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [4:0] pin_in;
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic       pw_d_r;
  assign pin_in = {vref_3p0, pwrok, ~pipe_req_n, sba_start, op_last};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
        end
        else
        begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate

  logic vref_s;
  logic pw_s;
  logic pipe_s;
  logic sba_s;
  logic last_s;
  assign {vref_s, pw_s, pipe_s, sba_s, last_s} = s2_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pw_d_r <= 1'b0;
    else
      pw_d_r <= pw_s;
  end

  logic pw_rise;
  assign pw_rise = pw_s & ~pw_d_r;

  // Mode held until next power-good rise; reads zero from reset until the first one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_3p0_r <= 1'b0;
    else if (pw_rise)
      mode_3p0_r <= vref_s;
  end
  ////////////////////////////////////////////////////////////////////
  // Wishbone slave
  logic        req;
  logic        hit;
  logic [31:0] bmask;
  logic [31:0] cmd_r;
  assign req   = wb_req.cyc & wb_req.stb;
  assign hit   = wb_req.adr == agpc_pkg::CMD_OFS;
  assign bmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                  {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

  // One wait state; unmapped reads return zero, writes dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o && hit)
        wb_dat_o <= cmd_r & agpc_pkg::RD_MASK;
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

  logic [31:0] wmask;
  assign wmask = agpc_pkg::WR_MASK & bmask;

  // Mode-dependent default loads when power-good rises, ahead of writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_r <= agpc_pkg::RST_V20;
    else if (pw_rise)
      cmd_r <= vref_s ? agpc_pkg::RST_V30 : agpc_pkg::RST_V20;
    else if (req && wb_req.we && wb_ack_o && hit)
      cmd_r <= (cmd_r & ~wmask) | (wb_req.dat & wmask);
  end

  logic [2:0] cal_code;
  logic [2:0] rsel;
  logic       en;
  logic       sba_on;
  assign cal_code = cmd_r[agpc_pkg::CAL_HI:agpc_pkg::CAL_LO];
  assign rsel     = cmd_r[agpc_pkg::RATE_HI:0];
  assign en       = cmd_r[agpc_pkg::EN_BIT];
  assign sba_on   = mode_3p0_r | cmd_r[agpc_pkg::SBA_BIT];
  ////////////////////////////////////////////////////////////////////
  // Rate decode and write protocol choice
  agpc_pkg::agpc_rate_t rate_nxt;
  always_comb
  begin
    rate_nxt = agpc_pkg::RATE_NONE;
    case (rsel)
      agpc_pkg::RSEL_0:
        rate_nxt = mode_3p0_r ? agpc_pkg::RATE_4X : agpc_pkg::RATE_1X;
      agpc_pkg::RSEL_1:
        rate_nxt = mode_3p0_r ? agpc_pkg::RATE_8X : agpc_pkg::RATE_2X;
      agpc_pkg::RSEL_2:
        rate_nxt = mode_3p0_r ? agpc_pkg::RATE_NONE : agpc_pkg::RATE_4X;
      default:
        rate_nxt = agpc_pkg::RATE_NONE;
    endcase
  end

  // Invalid rate codes fall back to PCI writes as the safe choice
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xfer_rate_r   <= agpc_pkg::RATE_NONE;
      fast_write_r  <= 1'b0;
      port_enable_r <= 1'b0;
      sba_enabled_r <= 1'b0;
    end
    else
    begin
      xfer_rate_r   <= rate_nxt;
      fast_write_r  <= cmd_r[agpc_pkg::FW_BIT]
                       && rate_nxt != agpc_pkg::RATE_1X
                       && rate_nxt != agpc_pkg::RATE_NONE;
      port_enable_r <= en;
      sba_enabled_r <= sba_on;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Calibration timer
  logic [CW-1:0] period;
  logic          cal_ok;
  logic [CW-1:0] cnt_r;
  always_comb
  begin
    period = CW'(CAL64_CYC);
    cal_ok = 1'b1;
    case (cal_code)
      agpc_pkg::CAL_4:   period = CW'(CAL4_CYC);
      agpc_pkg::CAL_16:  period = CW'(CAL16_CYC);
      agpc_pkg::CAL_64:  period = CW'(CAL64_CYC);
      agpc_pkg::CAL_256: period = CW'(CAL256_CYC);
      default:           cal_ok = 1'b0;
    endcase
  end

  // Reserved codes treated like no-calibration; counter parks at zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r       <= '0;
      cal_pulse_r <= 1'b0;
    end
    else if (!cal_ok)
    begin
      cnt_r       <= '0;
      cal_pulse_r <= 1'b0;
    end
    else if (cnt_r >= period - CW'(1))
    begin
      cnt_r       <= '0;
      cal_pulse_r <= 1'b1;
    end
    else
    begin
      cnt_r       <= cnt_r + CW'(1);
      cal_pulse_r <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Operation gating
  agpc_pkg::agpc_op_t op_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      op_r        <= agpc_pkg::OP_IDLE;
      op_accept_r <= 1'b0;
      op_issue_r  <= 1'b0;
      op_sba_r    <= 1'b0;
      op_busy_r   <= 1'b0;
    end
    else
    begin
      op_accept_r <= 1'b0;
      op_issue_r  <= 1'b0;
      case (op_r)
        agpc_pkg::OP_IDLE:
          if (en && pipe_s)
          begin
            op_r        <= agpc_pkg::OP_PIPE;
            op_accept_r <= 1'b1;
            op_sba_r    <= 1'b0;
            op_busy_r   <= 1'b1;
          end
          else if (en && sba_on && sba_s)
          begin
            op_r        <= agpc_pkg::OP_SBA;
            op_accept_r <= 1'b1;
            op_sba_r    <= 1'b1;
            op_busy_r   <= 1'b1;
          end
        // Enable is not looked at once an operation is under way
        agpc_pkg::OP_PIPE, agpc_pkg::OP_SBA:
          if (last_s)
          begin
            op_r       <= agpc_pkg::OP_IDLE;
            op_issue_r <= 1'b1;
            op_busy_r  <= 1'b0;
          end
        default:
          op_r <= agpc_pkg::OP_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_val;
    pw_rise |=> cmd_r == ($past(vref_s) ? agpc_pkg::RST_V30 : agpc_pkg::RST_V20);
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad default");
  property p_cal_none;
    !cal_ok [*2] |-> !cal_pulse_r;
  endproperty
  a_cal_none: assert property (p_cal_none) else $error("cal pulse");
  property p_sba_3p0;
    mode_3p0_r [*2] |-> sba_enabled_r;
  endproperty
  a_sba_3p0: assert property (p_sba_3p0) else $error("sba off");
  property p_disabled;
    op_r == agpc_pkg::OP_IDLE && !en |=> !op_accept_r;
  endproperty
  a_disabled: assert property (p_disabled) else $error("accepted");
  sequence s_in_sba;
    op_r == agpc_pkg::OP_SBA && !en;
  endsequence
  sequence s_issue;
    ##1 op_issue_r && op_sba_r && !op_busy_r;
  endsequence
  property p_sba_finish;
    s_in_sba ##0 last_s |-> s_issue;
  endproperty
  a_sba_finish: assert property (p_sba_finish) else $error("sba lost");
  property p_keep;
    op_busy_r && !last_s |=> op_busy_r && !op_issue_r;
  endproperty
  a_keep: assert property (p_keep) else $error("op dropped");
  property p_sba_gate;
    op_accept_r && op_sba_r |-> $past(sba_on) && $past(en);
  endproperty
  a_sba_gate: assert property (p_sba_gate) else $error("sba gate");
  property p_read_rsv;
    wb_ack_o |-> (wb_dat_o & ~agpc_pkg::RD_MASK) == 32'h0000_0000;
  endproperty
  a_read_rsv: assert property (p_read_rsv) else $error("rsv bits");
  property p_pci;
    !cmd_r[agpc_pkg::FW_BIT] || rate_nxt == agpc_pkg::RATE_1X |=> !fast_write_r;
  endproperty
  a_pci: assert property (p_pci) else $error("fast write");
  property p_rate3;
    mode_3p0_r && rsel == agpc_pkg::RSEL_1 |=> xfer_rate_r == agpc_pkg::RATE_8X;
  endproperty
  a_rate3: assert property (p_rate3) else $error("rate decode");
endmodule // agpc_command_reg
`default_nettype wire

// ---- tb/agpc_master_model.sv ----
// Behavioural graphics master that raises requests and ends operations
`default_nettype none
module agpc_master_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic req,
  input  wire logic kind,
  input  wire logic op_accept_r,
  output var  logic pipe_req_n,
  output var  logic sba_start,
  output var  logic op_last
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  // Request held until taken; the tail outlasts one bus write
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      pipe_req_n <= 1'b1;
      sba_start  <= 1'b0;
      op_last    <= 1'b0;
      cnt_r      <= 4'h0;
    end
    else
    begin
      op_last <= (cnt_r == 4'h1);
      if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      else if (op_accept_r)
        cnt_r <= 4'hC;
      pipe_req_n <= !(req && !kind && !op_accept_r && cnt_r == 4'h0);
      sba_start  <= req && kind && !op_accept_r && cnt_r == 4'h0;
    end
endmodule // agpc_master_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the port command register
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk, rst, vref_3p0, pwrok, req, kind;
  logic                   pipe_req_n, sba_start, op_last, wb_ack_o;
  logic                   mode_3p0_r, port_enable_r, sba_enabled_r, op_accept_r;
  logic                   op_sba_r, op_busy_r, op_issue_r, fast_write_r, cal_pulse_r;
  logic [31:0]            wb_dat_o, seed, d;
  agpc_pkg::agpc_wb_req_t wb_req;
  agpc_pkg::agpc_rate_t   xfer_rate_r;
  int                     n_mismatch, n_checks, n_acc, g;
  int                     cc[6] = '{0, 1, 2, 3, 5, 7};
  int                     per[6] = '{8, 12, 16, 20, 60, 60};
  logic [31:0]            rd_q[$];
  logic                   acc_q[$];

  agpc_command_reg #(.CAL4_CYC(8), .CAL16_CYC(12), .CAL64_CYC(16), .CAL256_CYC(20))
    agpc_command_reg_i (.clk, .rst, .wb_req, .wb_dat_o, .wb_ack_o, .vref_3p0, .pwrok,
    .pipe_req_n, .sba_start, .op_last, .mode_3p0_r, .port_enable_r, .sba_enabled_r,
    .op_accept_r, .op_sba_r, .op_busy_r, .op_issue_r, .fast_write_r, .xfer_rate_r,
    .cal_pulse_r);
  agpc_master_model agpc_master_model_i (.clk, .rst, .req, .kind, .op_accept_r,
    .pipe_req_n, .sba_start, .op_last);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wait_hi(ref logic s);
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (s !== 1'b1 && i < 60);
    if (i >= 60)
    begin
      n_mismatch++;
      $display("mismatch wait expected 1 seen 0");
      stop_test();
    end
  endtask
  // Request held until ack, then one idle cycle before the next
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dd,
                    input logic [31:0] e);
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, dd};
    if (!we)
      rd_q.push_back(e);
    wait_hi(wb_ack_o);
    wb_req <= '0;
  endtask
  task automatic wr(input logic [31:0] dd);
    wb(1'b1, agpc_pkg::CMD_OFS, dd, 32'h0);
  endtask
  task automatic rd(input logic [31:0] e);
    wb(1'b0, agpc_pkg::CMD_OFS, 32'h0, e);
  endtask
  task automatic set_mode(input logic v);
    rst <= 1'b1;
    pwrok <= 1'b0;
    vref_3p0 <= v;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pwrok <= 1'b1;
    repeat (5) @(posedge clk);
    chk("mode", {31'h0, v}, {31'h0, mode_3p0_r});
    rd(v ? agpc_pkg::RST_V30 : agpc_pkg::RST_V20);
  endtask
  task automatic op(input logic k, input logic drop);
    acc_q.push_back(k);
    kind <= k;
    req <= 1'b1;
    wait_hi(op_accept_r);
    req <= 1'b0;
    chk("busy", 32'h1, {31'h0, op_busy_r});
    if (drop)
      wr(32'h0);
    wait_hi(op_issue_r);
  endtask
  task automatic idle_req(input logic k);
    g = n_acc;
    kind <= k;
    req <= 1'b1;
    repeat (20) @(posedge clk);
    req <= 1'b0;
    repeat (5) @(posedge clk);
    chk("ignored", g, n_acc);
  endtask
  // Skips one edge so a pulse left from the old period is not measured
  task automatic cal_gap(output int n);
    @(posedge clk);
    n = 0;
    while (cal_pulse_r !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    n = 1;
    while (cal_pulse_r !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (wb_ack_o === 1'b1 && wb_req.we === 1'b0 && rd_q.size() > 0)
      chk("read", rd_q.pop_front(), wb_dat_o);
    if (op_accept_r === 1'b1)
    begin
      n_acc++;
      if (acc_q.size() > 0)
        chk("source", {31'h0, acc_q.pop_front()}, {31'h0, op_sba_r});
    end
  end

  initial
  begin
    rst = 1'b1;
    vref_3p0 = 1'b0;
    pwrok = 1'b0;
    req = 1'b0;
    kind = 1'b0;
    wb_req = '0;
    seed = 32'h85D5D207;
    for (int m = 0; m < 2; m++)
    begin
      set_mode(m[0]);
      for (int r = 0; r < 3; r++)
        for (int f = 0; f < 2; f++)
        begin
          d = 32'((f << 9) | 32 | (f << 4) | (1 << r));
          wr(d);
          repeat (3) @(posedge clk);
          // Top code is reserved in 3.0 signaling: no rate, PCI writes
          chk("rate", 32'((m && r == 2) ? 0 : r + 1 + 2 * m), {29'h0, xfer_rate_r});
          chk("fastwr", 32'(f && (m ? r < 2 : r > 0)), {31'h0, fast_write_r});
          chk("sba", 32'(f || m), {31'h0, sba_enabled_r});
          rd(d & agpc_pkg::RD_MASK);
        end
    end
    repeat (4)
    begin
      d = rnd();
      wr(d);
      rd(d & agpc_pkg::WR_MASK);
    end
    wb(1'b1, 8'hAC, 32'hFFFFFFFF, 32'h0);
    wb(1'b0, 8'hAC, 32'h0, 32'h0);
    set_mode(1'b0);
    wr(32'h0);
    idle_req(1'b0);
    wr(32'h100);
    op(1'b0, 1'b0);
    idle_req(1'b1);
    wr(32'h300);
    op(1'b1, 1'b1);
    chk("enable", 32'h0, {31'h0, port_enable_r});
    for (int c = 0; c < 6; c++)
    begin
      wr(32'(cc[c]) << 10);
      cal_gap(g);
      chk("calgap", per[c], g);
    end
    stop_test();
  end
endmodule // testbench
`default_nettype wire
